/* logic/pcnt_consts.vh */
// Contract
// - feature register is 16 bits, reset value 0x0100.
// - feature bit 1 picks output format: 0 standard, 1 alternative.
// - bit 2 with two counters: hold bit loads the second counter.
// - bit 3: rising edge of load bit loads active counters from output data.
// - bits 4..7 enable set/reset of first output, then second output.
// - mode 001: one 32-bit up/down counter, 24 bits in alternative format.
// - mode 010: two up counters, 16/16 standard, 8/16 alternative.
// - mode 100: 32-bit gated counter, stopped while gate low.
// - mode 101: 32-bit gated counter, stopped while gate high.
// - bit 11 selects direction: 0 up, 1 down.
// - bit 12 set: terminal bus accesses are serviced by polling.
// - single or gated mode: first output set/cleared at count 0x80000000.
// - overflow with an output function active clears that output.
// - single counter mode: second output follows counter bit 15.
// - two counters: outputs set/cleared at 0x8000 per bits 4,6 and 5,7.
`ifndef PCNT_CONSTS_VH
`define PCNT_CONSTS_VH
`define PCNT_FEAT_ADDR 8'h20
`define PCNT_CTRL_ADDR 8'h24
`define PCNT_DATA_ADDR 8'h28
`define PCNT_CNT0_ADDR 8'h2C
`define PCNT_CNT1_ADDR 8'h30
`define PCNT_STAT_ADDR 8'h34
`define PCNT_FEAT_RST 16'h0100
`define PCNT_FEAT_MASK 16'h1FFE
`define PCNT_B_ALT 1
`define PCNT_B_HOLD2 2
`define PCNT_B_LOADEN 3
`define PCNT_B_SET0 4
`define PCNT_B_CLR0 5
`define PCNT_B_SET1 6
`define PCNT_B_CLR1 7
`define PCNT_B_DOWN 11
`define PCNT_B_POLL 12
`define PCNT_MODE_LSB 8
`define PCNT_MODE_SINGLE 3'h1
`define PCNT_MODE_DUAL 3'h2
`define PCNT_MODE_GATE_LO 3'h4
`define PCNT_MODE_GATE_HI 3'h5
`define PCNT_CTRL_LOAD 5
`define PCNT_CTRL_HOLD 3
`define PCNT_THR32 32'h80000000
`define PCNT_THR16 16'h8000
`endif

/* logic/pcnt_top.v */
`timescale 1ns/1ps
`include "pcnt_consts.vh"
module pcnt_top
(
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   input wire pulse_a_i,
   input wire pulse_b_i,
   input wire gate_i,
   output reg first_output_o,
   output reg second_output_o,
   output reg poll_mode_o
);
////////////////////////////////////////////////////////////////////////////////
reg [15:0] feat;
reg [7:0] ctrl;
reg [31:0] odata;
reg [31:0] cnt0;
reg [15:0] cnt1;
reg load_q;
reg hold_q;
reg [1:0] ovf;
reg pa_s1, pa_s2, pa_d;
reg pb_s1, pb_s2, pb_d;
reg g_s1, g_s2;
wire [2:0] mode = feat[10:8];
wire alt = feat[`PCNT_B_ALT];
wire dual = (mode == `PCNT_MODE_DUAL);
wire single = (mode == `PCNT_MODE_SINGLE);
wire gated = (mode == `PCNT_MODE_GATE_LO) || (mode == `PCNT_MODE_GATE_HI);
wire down = feat[`PCNT_B_DOWN];
wire pa_rise = pa_s2 & ~pa_d;
wire pb_rise = pb_s2 & ~pb_d;
// gate low locks mode 100, gate high locks mode 101
wire gate_ok = (mode == `PCNT_MODE_GATE_LO) ? g_s2 : ~g_s2;
wire load_bit = ctrl[`PCNT_CTRL_LOAD];
wire hold_bit = ctrl[`PCNT_CTRL_HOLD];
// counter 1 load source is the hold bit when bit 2 is set
wire load_rise = feat[`PCNT_B_LOADEN] & load_bit & ~load_q;
wire load2_rise = feat[`PCNT_B_LOADEN] & feat[`PCNT_B_HOLD2] & hold_bit & ~hold_q;
wire hold_inh = hold_bit & ~(dual & feat[`PCNT_B_HOLD2]);
wire [31:0] wide_mask = alt ? 32'h00FFFFFF : 32'hFFFFFFFF;
wire [31:0] lo_mask = alt ? 32'h000000FF : 32'h0000FFFF;
wire step0 = pa_rise & ~hold_inh & ((single | dual) | (gated & gate_ok));
wire step1 = pb_rise & dual & ~hold_inh;
wire [31:0] c0_up = (cnt0 + 32'h00000001) & (dual ? lo_mask : wide_mask);
wire [31:0] c0_dn = (cnt0 - 32'h00000001) & wide_mask;
wire [31:0] next_cnt0 = (down & ~dual) ? c0_dn : c0_up;
wire ovf0 = step0 & (next_cnt0 == 32'h00000000) & ~(down & ~dual);
wire unf0 = step0 & down & ~dual & (cnt0 == 32'h00000000);
wire [15:0] next_cnt1 = cnt1 + 16'h0001;
wire ovf1 = step1 & (next_cnt1 == 16'h0000);
wire hit0 = step0 & (dual ? (next_cnt0[15:0] == `PCNT_THR16)
           : (next_cnt0 == `PCNT_THR32));
wire hit1 = step1 & (next_cnt1 == `PCNT_THR16);
wire acc = cyc_i & stb_i & ~ack_o;
////////////////////////////////////////////////////////////////////////////////
// input synchronisers; first stage feeds only the second
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      pa_s1 <= 1'b0;
      pa_s2 <= 1'b0;
      pa_d <= 1'b0;
      pb_s1 <= 1'b0;
      pb_s2 <= 1'b0;
      pb_d <= 1'b0;
      g_s1 <= 1'b0;
      g_s2 <= 1'b0;
   end
   else
   begin
      pa_s1 <= pulse_a_i;
      pa_s2 <= pa_s1;
      pa_d <= pa_s2;
      pb_s1 <= pulse_b_i;
      pb_s2 <= pb_s1;
      pb_d <= pb_s2;
      g_s1 <= gate_i;
      g_s2 <= g_s1;
   end
end
////////////////////////////////////////////////////////////////////////////////
// wishbone slave: one registered ack per access, one cycle after the request; unmapped reads give zero
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      feat <= `PCNT_FEAT_RST;
      ctrl <= 8'h00;
      odata <= 32'h00000000;
   end
   else
   begin
      ack_o <= acc;
      if (acc & we_i)
      begin
         if (adr_i == `PCNT_FEAT_ADDR)
         begin
            // bits 0 and 15..13 have no function and are kept at zero
            if (sel_i[0])
               feat[7:0] <= dat_i[7:0] & 8'hFE;
            if (sel_i[1])
               feat[15:8] <= dat_i[15:8] & 8'h1F;
         end
         else if (adr_i == `PCNT_CTRL_ADDR)
         begin
            if (sel_i[0])
               ctrl <= dat_i[7:0];
         end
         else if (adr_i == `PCNT_DATA_ADDR)
         begin
            if (sel_i[0])
               odata[7:0] <= dat_i[7:0];
            if (sel_i[1])
               odata[15:8] <= dat_i[15:8];
            if (sel_i[2])
               odata[23:16] <= dat_i[23:16];
            if (sel_i[3])
               odata[31:24] <= dat_i[31:24];
         end
      end
      if (acc & ~we_i)
      begin
         if (adr_i == `PCNT_FEAT_ADDR)
            dat_o <= {16'h0000, feat};
         else if (adr_i == `PCNT_CTRL_ADDR)
            dat_o <= {24'h000000, ctrl};
         else if (adr_i == `PCNT_DATA_ADDR)
            dat_o <= odata;
         else if (adr_i == `PCNT_CNT0_ADDR)
            dat_o <= cnt0;
         else if (adr_i == `PCNT_CNT1_ADDR)
            dat_o <= {16'h0000, cnt1};
         else if (adr_i == `PCNT_STAT_ADDR)
            dat_o <= {28'h0000000, ovf, second_output_o, first_output_o};
         else
            dat_o <= 32'h00000000;
      end
   end
end
////////////////////////////////////////////////////////////////////////////////
// counters; a load beats a pulse in the same cycle, except that a counter 1 pulse beats a load-bit load of counter 1
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      cnt0 <= 32'h00000000;
      cnt1 <= 16'h0000;
      load_q <= 1'b0;
      hold_q <= 1'b0;
      ovf <= 2'b00;
      poll_mode_o <= 1'b0;
   end
   else
   begin
      load_q <= load_bit;
      hold_q <= hold_bit;
      poll_mode_o <= feat[`PCNT_B_POLL];
      if (load_rise)
      begin
         // in dual mode data low half goes to counter 0, high half to counter 1 when bit 2 is clear
         cnt0 <= (dual ? {16'h0000, odata[15:0]} & lo_mask : odata & wide_mask);
         if (dual & ~feat[`PCNT_B_HOLD2])
            cnt1 <= odata[31:16];
      end
      else if (step0)
         cnt0 <= next_cnt0;
      if (load2_rise & dual)
         cnt1 <= odata[31:16];
      else if (step1)
         cnt1 <= next_cnt1;
      if (ovf0 | unf0)
         ovf[0] <= 1'b1;
      else if (load_rise)
         ovf[0] <= 1'b0;
      if (ovf1)
         ovf[1] <= 1'b1;
      else if (load_rise | load2_rise)
         ovf[1] <= 1'b0;
   end
end
////////////////////////////////////////////////////////////////////////////////
// outputs; overflow clears win over a threshold set in the same cycle
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      first_output_o <= 1'b0;
      second_output_o <= 1'b0;
   end
   else
   begin
      if ((ovf0 | unf0) & (feat[`PCNT_B_SET0] | feat[`PCNT_B_CLR0]))
         first_output_o <= 1'b0;
      else if (hit0 & feat[`PCNT_B_SET0])
         first_output_o <= 1'b1;
      else if (hit0 & feat[`PCNT_B_CLR0])
         first_output_o <= 1'b0;
      if (dual)
      begin
         if (ovf1 & (feat[`PCNT_B_SET1] | feat[`PCNT_B_CLR1]))
            second_output_o <= 1'b0;
         else if (hit1 & feat[`PCNT_B_SET1])
            second_output_o <= 1'b1;
         else if (hit1 & feat[`PCNT_B_CLR1])
            second_output_o <= 1'b0;
      end
      else if (single)
         second_output_o <= cnt0[15];
   end
end
endmodule

/* sim/pcnt_props.sv */
`timescale 1ns/1ps
module pcnt_props
(
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   input wire first_output_o,
   input wire poll_mode_o
);
   wire wfeat = ack_o && we_i && adr_i == 8'h20 && sel_i[1];
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_ans;
      ack_o ##1 !ack_o;
   endsequence
   a_ack_pulse: assert property (s_req |=> s_ans)
      else $error("ack not one pulse");
   a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_poll_copy: assert property (wfeat |-> ##2 poll_mode_o == $past(dat_i[12], 2))
      else $error("poll copy wrong");
   a_poll_cause: assert property ($changed(poll_mode_o) |-> $past(wfeat) || $past(wfeat, 2))
      else $error("poll changed alone");
   a_feat_zero: assert property (ack_o && !we_i && adr_i == 8'h20 |-> !dat_o[0] && dat_o[31:13] == 0)
      else $error("dead feature bits set");
   a_unmap_zero: assert property (ack_o && !we_i && adr_i > 8'h34 |-> dat_o == 0)
      else $error("unmapped read not zero");
   a_dat_hold: assert property ($changed(dat_o) |-> ack_o && !we_i)
      else $error("read data moved");
   a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !first_output_o && !poll_mode_o)
      else $error("outputs live after reset");
endmodule
bind pcnt_top pcnt_props pcnt_props_i(.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
   .dat_i, .dat_o, .ack_o, .first_output_o, .poll_mode_o);

/* sim/pcnt_src.sv */
`timescale 1ns/1ps
module pcnt_src
(
   input wire clk_i,
   input wire go_i,
   output reg pulse_o = 0
);
   reg [2:0] ph = 0;
   // three cycles high, then low until go_i comes again: the two-stage synchroniser cannot miss it
   always @(posedge clk_i)
   begin
      ph <= go_i ? 3'h6 : ph - (ph != 0);
      pulse_o <= ph > 3;
   end
endmodule

/* sim/test_pcnt_top.sv */
`timescale 1ns/1ps
module test_pcnt_top;
   reg clk_i = 0, rst_i = 1, req = 0, we = 0, go = 0, gate = 0;
   reg [7:0] adr = 0;
   reg [31:0] wd = 0, q;
   wire [31:0] rd;
   wire ack, a0, a1, pm, pls;
   integer fail_count = 0, num_checks = 0;
   always #10 clk_i = ~clk_i;
   pcnt_src pcnt_src_i(.clk_i(clk_i), .go_i(go), .pulse_o(pls));
   pcnt_top pcnt_top_i(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req), .stb_i(req), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(wd), .dat_o(rd), .ack_o(ack), .pulse_a_i(pls),
      .pulse_b_i(pls), .gate_i(gate), .first_output_o(a0), .second_output_o(a1),
      .poll_mode_o(pm));
   task finish_test;
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input [31:0] g, input [31:0] e);
      num_checks = num_checks + 1;
      if (g !== e)
      begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      integer k;
      begin
         req <= 1;
         we <= w;
         adr <= a;
         wd <= d;
         k = 0;
         @(posedge clk_i);
         while (ack !== 1'b1 && k < 20)
         begin
            k = k + 1;
            @(posedge clk_i);
         end
         if (ack !== 1'b1)
         begin
            fail_count = fail_count + 1;
            finish_test;
         end
         q = rd;
         req <= 0;
         @(posedge clk_i);
      end
   endtask
   task rc(input [7:0] a, input [31:0] e);
      bus(0, a, 0);
      chk(q, e);
   endtask
   task ld(input [31:0] d);
      bus(1, 8'h28, d);
      bus(1, 8'h24, 0);
      bus(1, 8'h24, 32'h20);
   endtask
   // wait covers pulse length plus the three-edge sync delay
   task pl;
      go <= 1;
      @(posedge clk_i);
      go <= 0;
      repeat (12) @(posedge clk_i);
   endtask
   task t_feat;
      rc(8'h20, 32'h0100);
      bus(1, 8'h20, 32'hFFFF);
      rc(8'h20, 32'h1FFE);
      chk({31'h0, pm}, 1);
      rc(8'h40, 0);
   endtask
   task t_single;
      bus(1, 8'h20, 32'h0118);
      ld(32'h7FFF);
      pl;
      rc(8'h2C, 32'h8000);
      chk({31'h0, a1}, 1);
      ld(32'h7FFFFFFF);
      pl;
      chk({31'h0, a0}, 1);
      ld(32'hFFFFFFFF);
      pl;
      rc(8'h2C, 0);
      chk({31'h0, a0}, 0);
      rc(8'h34, 32'h4);
      bus(1, 8'h20, 32'h0908);
      ld(5);
      pl;
      rc(8'h2C, 4);
   endtask
   task t_dual;
      bus(1, 8'h20, 32'h0218);
      ld(32'h00037FFF);
      pl;
      rc(8'h2C, 32'h8000);
      rc(8'h30, 4);
      chk({31'h0, a0}, 1);
      bus(1, 8'h20, 32'h021A);
      ld(32'h000100FF);
      pl;
      rc(8'h2C, 0);
      rc(8'h30, 2);
      bus(1, 8'h20, 32'h020C);
      bus(1, 8'h28, 32'h00090000);
      bus(1, 8'h24, 8);
      rc(8'h30, 9);
      bus(1, 8'h20, 32'h0248);
      ld(32'h7FFF0000);
      pl;
      chk({31'h0, a1}, 1);
      bus(1, 8'h20, 32'h02A8);
      ld(32'h7FFF7FFF);
      pl;
      chk({31'h0, a1}, 0);
   endtask
   task t_gate;
      bus(1, 8'h20, 32'h0408);
      ld(10);
      pl;
      rc(8'h2C, 10);
      gate <= 1;
      pl;
      rc(8'h2C, 11);
      bus(1, 8'h20, 32'h0508);
      pl;
      rc(8'h2C, 11);
   endtask
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      t_feat;
      t_single;
      t_dual;
      t_gate;
      finish_test;
   end
endmodule
